// ---- rtl/bcr_gate.sv ----
`timescale 1ns/1ps
// registered request gate: a lane passes only while enabled
module bcr_gate #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // lanes
  input wire logic [W-1:0] req,
  input wire logic [W-1:0] en,
  output logic [W-1:0] grant
);
  // one cycle of latency keeps every grant a clean flop output
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      grant <= '0;
    end else begin
      grant <= req & en;
    end
  end
endmodule

// ---- rtl/bcr_pkg.sv ----
package bcr_pkg;
  // ------------------------------------------------------------
  // configuration map
  // ------------------------------------------------------------
  localparam logic [11:0] BCR_CMD_OFS = 12'h004;
  localparam int BCR_ADDR_W = 12;
  localparam int BCR_DATA_W = 32;
  localparam int BCR_BE_W = 4;

  // ------------------------------------------------------------
  // command half field positions
  // ------------------------------------------------------------
  localparam int BCR_IO_EN_BIT = 0;
  localparam int BCR_MEM_EN_BIT = 1;
  localparam int BCR_MASTER_EN_BIT = 2;
  localparam int BCR_SPECIAL_BIT = 3;
  localparam int BCR_MWI_BIT = 4;
  localparam int BCR_PALETTE_BIT = 5;
  localparam int BCR_PARITY_EN_BIT = 6;
  localparam int BCR_WAIT_BIT = 7;
  localparam int BCR_SERR_EN_BIT = 8;
  localparam int BCR_FBB_BIT = 9;
  localparam int BCR_INT_DIS_BIT = 10;

  // ------------------------------------------------------------
  // status half field position
  // ------------------------------------------------------------
  localparam int BCR_MDPE_BIT = 24;

  // ------------------------------------------------------------
  // reset values and writable masks
  // ------------------------------------------------------------
  localparam logic [15:0] BCR_CMD_RESET = 16'h0000;
  localparam logic [15:0] BCR_CMD_WR_MASK = 16'h0547;
  localparam logic BCR_MDPE_RESET = 1'b0;

  // ------------------------------------------------------------
  // gated request lanes and synchronised pin count
  // ------------------------------------------------------------
  localparam int BCR_LANES = 5;
  localparam int BCR_SYNC_W = 2;
endpackage

// ---- rtl/bcr_sync.sv ----
`timescale 1ns/1ps
// two-stage synchroniser for pin levels
module bcr_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      meta <= '0;
      sync_out <= '0;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule

// ---- rtl/bcr_top.sv ----
// Function
// [R1] io enable off ignores primary io
// [R2] memory enable gates primary memory reads
// [R3] master enable off blocks both directions
// [R4] master enable on forwards secondary as master
// [R5] special cycle bit reads zero
// [R6] write-invalidate bit reads zero, never originated
// [R7] palette snoop bit reads zero
// [R8] parity enable lets errors set flag
// [R9] wait cycle bit reads zero
// [R10] error enable reports messages in forward mode
// [R11] fast back-to-back bit reads zero
// [R12] interrupt disable holds legacy interrupt high
// [R13] parity flag set only while enabled
// [R14] bits fifteen to eleven read zero
`timescale 1ns/1ps
module bcr_top
  import bcr_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // configuration access port
  input wire logic cfg_rd,
  input wire logic cfg_wr,
  input wire logic [bcr_pkg::BCR_ADDR_W-1:0] cfg_addr,
  input wire logic [bcr_pkg::BCR_BE_W-1:0] cfg_be,
  input wire logic [bcr_pkg::BCR_DATA_W-1:0] cfg_wdata,
  output logic [bcr_pkg::BCR_DATA_W-1:0] cfg_rdata,
  output logic cfg_rd_valid,
  // primary side target requests
  input wire logic pri_io_req,
  output logic pri_io_accept,
  input wire logic pri_mem_rd_req,
  output logic pri_mem_rd_accept,
  // forwarding from the secondary side
  input wire logic fwd_req,
  output logic pri_master_start,
  input wire logic sec_req,
  output logic sec_claim,
  // error events
  input wire logic pri_poison_cpl,
  input wire logic pri_poison_wr,
  input wire logic pri_parity_err,
  input wire logic fatal_err,
  input wire logic nonfatal_err,
  output logic err_msg_send,
  output logic system_error_out_n,
  // pins from outside the clock domain
  input wire logic forward_mode_pin,
  input wire logic int_req_pin,
  output logic legacy_interrupt_a_n
);
  import bcr_pkg::*;

  logic [15:0] cmd;
  logic mdpe;
  logic [BCR_SYNC_W-1:0] pin_sync;
  logic [BCR_LANES-1:0] lane_req;
  logic [BCR_LANES-1:0] lane_en;
  logic [BCR_LANES-1:0] lane_grant;
  logic [15:0] next_cmd;
  logic next_mdpe;

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  wire hit = (cfg_addr == BCR_CMD_OFS);
  wire wr_hit = cfg_wr && hit;
  wire rd_hit = cfg_rd && hit;
  wire fwd_mode = pin_sync[0];
  wire int_sync = pin_sync[1];
  wire io_en = cmd[BCR_IO_EN_BIT];
  wire mem_en = cmd[BCR_MEM_EN_BIT];
  wire master_en = cmd[BCR_MASTER_EN_BIT];
  wire parity_en = cmd[BCR_PARITY_EN_BIT];
  wire serr_en = cmd[BCR_SERR_EN_BIT];
  wire int_dis = cmd[BCR_INT_DIS_BIT];

  // ------------------------------------------------------------
  // command half write path
  // ------------------------------------------------------------
  // byte enables select lanes; read-only and reserved bits stay zero
  wire [15:0] be_mask = {{8{cfg_be[1]}}, {8{cfg_be[0]}}};
  wire [15:0] wr_mask = be_mask & BCR_CMD_WR_MASK; // R5 R6 R7 R9 R11 R14
  wire [15:0] cmd_wr_val = (cmd & ~wr_mask) | (cfg_wdata[15:0] & wr_mask);
  assign next_cmd = wr_hit ? cmd_wr_val : cmd;

  // ------------------------------------------------------------
  // master data parity error flag
  // ------------------------------------------------------------
  // set wins over a same-cycle write-one-to-clear
  wire mdpe_event = pri_poison_cpl || pri_poison_wr || pri_parity_err;
  wire mdpe_set = parity_en && mdpe_event; // R8 R13
  wire mdpe_clr = wr_hit && cfg_be[3] && cfg_wdata[BCR_MDPE_BIT];
  assign next_mdpe = mdpe_set || (mdpe && !mdpe_clr);

  // registers
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cmd <= BCR_CMD_RESET;
      mdpe <= BCR_MDPE_RESET;
    end else begin
      cmd <= next_cmd;
      mdpe <= next_mdpe;
    end
  end

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------
  // status bits other than the parity flag are outside this block
  wire [31:0] rd_word = {7'h00, mdpe, 8'h00, cmd};
  wire [31:0] rd_val = rd_hit ? rd_word : 32'h0000_0000;

  // read data holds until the next read
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cfg_rdata <= 32'h0000_0000;
      cfg_rd_valid <= 1'b0;
    end else begin
      cfg_rd_valid <= cfg_rd;
      if (cfg_rd) begin
        cfg_rdata <= rd_val;
      end
    end
  end

  // ------------------------------------------------------------
  // pins
  // ------------------------------------------------------------
  // strap and interrupt request arrive unsynchronised
  bcr_sync #(
    .W(BCR_SYNC_W)
  ) u_sync (
    .core_clk(core_clk),
    .nrst(nrst),
    .async_in({int_req_pin, forward_mode_pin}),
    .sync_out(pin_sync)
  );

  // ------------------------------------------------------------
  // behaviour gating
  // ------------------------------------------------------------
  assign lane_req = {fatal_err || nonfatal_err, sec_req, fwd_req,
                     pri_mem_rd_req, pri_io_req};
  assign lane_en = {serr_en && fwd_mode, // R10
                    master_en, // R3
                    master_en, // R4
                    mem_en, // R2
                    io_en}; // R1

  bcr_gate #(
    .W(BCR_LANES)
  ) u_gate (
    .core_clk(core_clk),
    .nrst(nrst),
    .req(lane_req),
    .en(lane_en),
    .grant(lane_grant)
  );

  // outputs must be flops, so the grants are copied as registered
  assign pri_io_accept = lane_grant[0];
  assign pri_mem_rd_accept = lane_grant[1];
  assign pri_master_start = lane_grant[2];
  assign sec_claim = lane_grant[3];
  assign err_msg_send = lane_grant[4];

  // ------------------------------------------------------------
  // pin drivers
  // ------------------------------------------------------------
  // error pin pulses with the message; interrupt masked by disable
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      system_error_out_n <= 1'b1;
      legacy_interrupt_a_n <= 1'b1;
    end else begin
      system_error_out_n <= !(lane_req[4] && lane_en[4]); // R10
      legacy_interrupt_a_n <= !(int_sync && !int_dis); // R12
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  a_io_ignored: assert property ( // R1
    pri_io_req && !io_en |=> !pri_io_accept
  ) else $error("io accepted while io enable clear");

  a_io_taken: assert property ( // R1
    pri_io_req && io_en |=> pri_io_accept
  ) else $error("io not accepted while enabled");

  a_mem_read: assert property ( // R2
    pri_mem_rd_accept |-> $past(mem_en) && $past(pri_mem_rd_req)
  ) else $error("memory read accepted without enable");

  a_master_off: assert property ( // R3
    !master_en |=> !pri_master_start && !sec_claim
  ) else $error("master activity while master enable clear");

  a_master_fwd: assert property ( // R4
    fwd_req && master_en ##1 1'b1 |-> pri_master_start
  ) else $error("forward not mastered while enabled");

  a_ro_zero: assert property ( // R5 R6 R7 R9 R11 R14
    cfg_rd_valid |-> (cfg_rdata[15:0] & ~BCR_CMD_WR_MASK) == 16'h0000
  ) else $error("read-only command bit read nonzero");

  a_mdpe_gate: assert property ( // R13
    !parity_en && !mdpe && !mdpe_clr |=> !mdpe
  ) else $error("parity flag set while response disabled");

  a_mdpe_set: assert property ( // R8
    parity_en && mdpe_event |=> mdpe
  ) else $error("parity flag missed an enabled error");

  a_err_msg: assert property ( // R10
    err_msg_send |-> $past(serr_en) && $past(fwd_mode)
  ) else $error("error message sent without enable");

  a_int_block: assert property ( // R12
    int_dis |=> legacy_interrupt_a_n
  ) else $error("legacy interrupt asserted while disabled");
endmodule

// ---- tb/bcr_host.sv ----
`timescale 1ns/1ps
// host side: issues config accesses between clock edges
module bcr_host
  import bcr_pkg::*;
(
  // clock
  input wire logic core_clk,
  // access path
  output logic cfg_rd,
  output logic cfg_wr,
  output logic [bcr_pkg::BCR_ADDR_W-1:0] cfg_addr,
  output logic [bcr_pkg::BCR_BE_W-1:0] cfg_be,
  output logic [bcr_pkg::BCR_DATA_W-1:0] cfg_wdata
);
  initial {cfg_rd, cfg_wr, cfg_addr, cfg_be, cfg_wdata} = '0;

  // one-cycle strobe; idle bus shows inverted values, not stale ones
  task automatic acc(input logic w, input logic [11:0] a,
                     input logic [3:0] b, input logic [31:0] d);
    @(negedge core_clk);
    cfg_wr = w;
    cfg_rd = !w;
    cfg_addr = a;
    cfg_be = b;
    cfg_wdata = d;
    @(negedge core_clk);
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    cfg_addr = ~a;
    cfg_be = ~b;
    cfg_wdata = ~d;
  endtask
endmodule

// ---- tb/tb.sv ----
`timescale 1ns/1ps
module tb;
  import bcr_pkg::*;
  logic core_clk, nrst, cfg_rd, cfg_wr, cfg_rd_valid;
  logic [11:0] cfg_addr;
  logic [3:0] cfg_be;
  logic [31:0] cfg_wdata, cfg_rdata;
  logic pri_io_req, pri_io_accept, pri_mem_rd_req, pri_mem_rd_accept;
  logic fwd_req, pri_master_start, sec_req, sec_claim;
  logic pri_poison_cpl, pri_poison_wr, pri_parity_err, fatal_err;
  logic nonfatal_err, err_msg_send, system_error_out_n;
  logic forward_mode_pin, int_req_pin, legacy_interrupt_a_n;
  int fail_count, num_checks;
  logic [31:0] exp_q[$];
  logic [15:0] c;
  logic fm;

  bcr_top uut (.*);
  bcr_host u_host (.*);

  // ----------------------------------------------------------
  // clock, checking, verdict
  // ----------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic results();
    // a read whose valid never came leaves its note behind
    if (exp_q.size() != 0) begin
      fail_count++;
      $display("ERROR cfg_rd_valid expected %0d seen %0d", 0, exp_q.size());
    end
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // read data matched against the oldest note
  always @(negedge core_clk) begin
    if (cfg_rd_valid === 1'b1)
      chk("cfg_rdata", exp_q.pop_front(), cfg_rdata);
  end

  // ----------------------------------------------------------
  // stimulus helpers
  // ----------------------------------------------------------
  task automatic wr(input logic [11:0] a, input logic [3:0] b,
                    input logic [31:0] d);
    u_host.acc(1'b1, a, b, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    u_host.acc(1'b0, a, 4'hF, 32'h0);
  endtask

  // all lanes requested at once; grant must follow each enable
  task automatic lanes(input logic [15:0] k, input logic f);
    logic e;
    e = k[8] & f;
    forward_mode_pin = f;
    repeat (3) @(negedge core_clk);
    {pri_io_req, pri_mem_rd_req, fwd_req, sec_req} = 4'hF;
    {fatal_err, nonfatal_err} = 2'($urandom_range(1, 3));
    @(negedge core_clk);
    chk("io_accept", 32'(k[0]), 32'(pri_io_accept));
    chk("mem_accept", 32'(k[1]), 32'(pri_mem_rd_accept));
    chk("master", 32'(k[2]), 32'(pri_master_start));
    chk("sec_claim", 32'(k[2]), 32'(sec_claim));
    chk("err_msg", 32'(e), 32'(err_msg_send));
    chk("serr_n", 32'(!e), 32'(system_error_out_n));
    {pri_io_req, pri_mem_rd_req, fwd_req, sec_req} = 4'h0;
    {fatal_err, nonfatal_err} = 2'b00;
  endtask

  // one-cycle pulse of one error event
  task automatic ev(input int i);
    @(negedge core_clk);
    {pri_poison_cpl, pri_poison_wr, pri_parity_err} = 3'(3'b100 >> i);
    @(negedge core_clk);
    {pri_poison_cpl, pri_poison_wr, pri_parity_err} = 3'b000;
  endtask

  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial begin
    void'($urandom(32'h563a));
    nrst = 1'b0;
    {pri_io_req, pri_mem_rd_req, fwd_req, sec_req, fatal_err} = '0;
    {nonfatal_err, forward_mode_pin, int_req_pin} = '0;
    {pri_poison_cpl, pri_poison_wr, pri_parity_err} = '0;
    repeat (20) @(negedge core_clk);
    nrst = 1'b1;
    rd(BCR_CMD_OFS, 32'h0);
    wr(BCR_CMD_OFS, 4'hF, '1);
    rd(BCR_CMD_OFS, 32'h0000_0547);
    wr(12'h008, 4'hF, 32'h0);
    rd(12'h008, 32'h0);
    rd(BCR_CMD_OFS, 32'h0000_0547);
    // corner commands first, then random ones
    for (int i = 0; i < 8; i++) begin
      c = (i == 0) ? 16'h0 : 16'($urandom) & 16'h0547;
      c = (i == 1) ? 16'h0547 : c;
      fm = (i == 1) ? 1'b1 : 1'($urandom);
      wr(BCR_CMD_OFS, 4'h3, {16'h0, c});
      rd(BCR_CMD_OFS, {16'h0, c});
      lanes(c, fm);
    end
    // parity flag: blocked while disabled, set, then write-one-clear
    for (int i = 0; i < 3; i++) begin
      wr(BCR_CMD_OFS, 4'h3, 32'h0);
      ev(i);
      rd(BCR_CMD_OFS, 32'h0);
      wr(BCR_CMD_OFS, 4'h1, 32'h40);
      ev(i);
      rd(BCR_CMD_OFS, 32'h0100_0040);
      wr(BCR_CMD_OFS, 4'h8, 32'h0100_0000);
      rd(BCR_CMD_OFS, 32'h40);
    end
    // interrupt passes, then the disable bit blocks it
    wr(BCR_CMD_OFS, 4'h3, 32'h0);
    int_req_pin = 1'b1;
    repeat (4) @(negedge core_clk);
    chk("inta_n", 32'h0, 32'(legacy_interrupt_a_n));
    wr(BCR_CMD_OFS, 4'h3, 32'h400);
    @(negedge core_clk);
    chk("inta_n", 32'h1, 32'(legacy_interrupt_a_n));
    int_req_pin = 1'b0;
    repeat (4) @(negedge core_clk);
    results();
  end

  // watchdog: the run needs well under a thousand cycles
  initial begin
    repeat (5000) @(negedge core_clk);
    fail_count++;
    results();
  end
endmodule
